// ==== src/dtf_params.svh ====
// Register addresses, field positions and reset values of the task file
`ifndef DTF_PARAMS_SVH
`define DTF_PARAMS_SVH
`define DTF_ADR_DATA 3'h0
`define DTF_ADR_ERR_FEAT 3'h1
`define DTF_ADR_SECT_CNT 3'h2
`define DTF_ADR_SECT_NUM 3'h3
`define DTF_ADR_CYL_LOW 3'h4
`define DTF_ADR_CYL_HIGH 3'h5
`define DTF_ADR_UNIT_HEAD 3'h6
`define DTF_ADR_CMD_STAT 3'h7
`define DTF_ADR_CTL 3'h6
`define DTF_ADR_OBSOLETE 3'h7
`define DTF_CTL_SWRST_BIT 2
`define DTF_CTL_INTDIS_BIT 1
`define DTF_UH_LBA_BIT 6
`define DTF_UH_DEV_BIT 4
`define DTF_ST_BUSY_BIT 7
`define DTF_ST_DREQ_BIT 3
`define DTF_RST_BYTE 8'h00
`define DTF_RST_CTL 8'h00
`define DTF_RST_UNIT_HEAD 8'ha0
`endif

// ==== src/dtf_pkg.sv ====
// Types shared by the task file blocks
package dtf_pkg;
    typedef enum logic [1:0] {DTF_ACC_NONE, DTF_ACC_CMD, DTF_ACC_CTL, DTF_ACC_BAD} dtf_acc_t;
    typedef enum logic {DTF_XFER_IDLE, DTF_XFER_MOVE} dtf_xfer_t;
endpackage : dtf_pkg

// ==== src/dtf_strobe_edge.sv ====
// Rising and falling edge detector for an active low host strobe
`timescale 1ns/1ps
`default_nettype none
module dtf_strobe_edge (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic strobe_n,
    output logic fall,
    output logic rise
);
    logic prev_q;

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            prev_q <= 1'b1;
        else
            prev_q <= strobe_n;
    end

    assign fall = prev_q & ~strobe_n;
    assign rise = ~prev_q & strobe_n;
endmodule : dtf_strobe_edge
`default_nettype wire

// ==== src/dtf_regs.sv ====
// Device side task file register bank with PIO and DMA data paths
`timescale 1ns/1ps
`default_nettype none
`include "dtf_params.svh"
module dtf_regs #(
    parameter logic UNIT_ID = 1'b0
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic cmd_sel_n,
    input wire logic ctl_sel_n,
    input wire logic [2:0] reg_adr,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic dma_ack_n,
    input wire logic [15:0] dd_in,
    output logic [15:0] dd_out,
    output logic [15:0] dd_oe_n,
    output logic intr_out,
    output logic intr_oe_n,
    input wire logic [7:0] dev_status,
    input wire logic intr_raise,
    input wire logic dma_req,
    input wire logic wide_xfer,
    input wire logic media_fail,
    input wire logic [15:0] fail_cyl,
    input wire logic [3:0] fail_head,
    input wire logic [15:0] pio_rd_word,
    input wire logic [15:0] dma_rd_word,
    output logic cmd_start,
    output logic [7:0] cmd_code_q,
    output logic [7:0] prm_feat_q,
    output logic [7:0] prm_cnt_q,
    output logic [7:0] prm_sect_q,
    output logic [15:0] prm_cyl_q,
    output logic [7:0] prm_uh_q,
    output logic [7:0] err_in,
    output logic [7:0] feat_q,
    output logic [7:0] cnt_q,
    output logic [7:0] sect_q,
    output logic soft_rst_q,
    output logic unit_sel,
    output logic pio_wr_stb,
    output logic pio_rd_stb,
    output logic dma_wr_stb,
    output logic dma_rd_stb,
    output logic [15:0] wr_word_q
);
    import dtf_pkg::*;

    logic rd_fall, rd_rise, wr_fall, wr_rise;
    dtf_acc_t acc_d, acc_q;
    logic [2:0] adr_q;
    logic dma_q;
    dtf_xfer_t xfer_q;
    logic [7:0] cyl_low_q, cyl_high_q, uh_q, ctl_q;
    logic intr_pend_q;
    logic busy, dreq;

    dtf_strobe_edge u_rd_edge (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .strobe_n(rd_n),
        .fall(rd_fall),
        .rise(rd_rise)
    );

    dtf_strobe_edge u_wr_edge (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .strobe_n(wr_n),
        .fall(wr_fall),
        .rise(wr_rise)
    );

    assign busy = dev_status[`DTF_ST_BUSY_BIT];
    assign dreq = dev_status[`DTF_ST_DREQ_BIT];
    assign err_in = 8'h00;

    always_comb
    begin
        unique case ({cmd_sel_n, ctl_sel_n})
            2'b01: acc_d = DTF_ACC_CMD;
            2'b10: acc_d = DTF_ACC_CTL;
            2'b00: acc_d = DTF_ACC_BAD;
            default: acc_d = DTF_ACC_NONE;
        endcase
    end

    // Selects latched at the strobe's leading edge, held for the whole cycle
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            acc_q <= DTF_ACC_NONE;
            adr_q <= 3'h0;
            dma_q <= 1'b0;
        end
        else if (rd_fall || wr_fall)
        begin
            acc_q <= acc_d;
            adr_q <= reg_adr;
            dma_q <= ~dma_ack_n & dma_req;
        end
    end

    // Data lands on the strobe's trailing edge
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            wr_word_q <= 16'h0000;
        else if (wr_rise)
            // Port words are always full width, whatever the PIO width
            wr_word_q <= (wide_xfer || dma_q) ? dd_in : {8'h00, dd_in[7:0]};
    end

    logic wr_cmd, wr_ctl;
    assign wr_cmd = wr_rise && acc_q == DTF_ACC_CMD && !dma_q;
    assign wr_ctl = wr_rise && acc_q == DTF_ACC_CTL && !dma_q && adr_q == `DTF_ADR_CTL;

    // Busy device ignores writes to the feature through unit/head registers
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            feat_q <= `DTF_RST_BYTE;
            cnt_q <= `DTF_RST_BYTE;
            sect_q <= `DTF_RST_BYTE;
            cyl_low_q <= `DTF_RST_BYTE;
            cyl_high_q <= `DTF_RST_BYTE;
            uh_q <= `DTF_RST_UNIT_HEAD;
        end
        else if (media_fail)
        begin
            cyl_low_q <= fail_cyl[7:0];
            cyl_high_q <= fail_cyl[15:8];
            uh_q[3:0] <= fail_head;
        end
        else if (wr_cmd && !busy)
        begin
            unique case (adr_q)
                `DTF_ADR_ERR_FEAT: feat_q <= dd_in[7:0];
                `DTF_ADR_SECT_CNT: cnt_q <= dd_in[7:0];
                `DTF_ADR_SECT_NUM: sect_q <= dd_in[7:0];
                `DTF_ADR_CYL_LOW: cyl_low_q <= dd_in[7:0];
                `DTF_ADR_CYL_HIGH: cyl_high_q <= dd_in[7:0];
                `DTF_ADR_UNIT_HEAD: uh_q <= dd_in[7:0];
                default: ;
            endcase
        end
    end

    // Bit 0 is forced low whatever the host writes
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            ctl_q <= `DTF_RST_CTL;
        else if (wr_ctl)
            ctl_q <= {5'h00, dd_in[2:1], 1'b0};
    end

    assign soft_rst_q = ctl_q[`DTF_CTL_SWRST_BIT];
    assign unit_sel = uh_q[`DTF_UH_DEV_BIT] == UNIT_ID;

    // Command write snapshots the parameter set
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            cmd_start <= 1'b0;
            cmd_code_q <= `DTF_RST_BYTE;
            prm_feat_q <= `DTF_RST_BYTE;
            prm_cnt_q <= `DTF_RST_BYTE;
            prm_sect_q <= `DTF_RST_BYTE;
            prm_cyl_q <= 16'h0000;
            prm_uh_q <= `DTF_RST_BYTE;
        end
        else
        begin
            cmd_start <= 1'b0;
            if (wr_cmd && adr_q == `DTF_ADR_CMD_STAT && !busy && !dreq)
            begin
                cmd_start <= 1'b1;
                cmd_code_q <= dd_in[7:0];
                prm_feat_q <= feat_q;
                prm_cnt_q <= cnt_q;
                prm_sect_q <= sect_q;
                prm_cyl_q <= {cyl_high_q, cyl_low_q};
                prm_uh_q <= uh_q;
            end
        end
    end

    // Set wins over clear
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            intr_pend_q <= 1'b0;
        else if (intr_raise)
            intr_pend_q <= 1'b1;
        else if (soft_rst_q || cmd_start)
            intr_pend_q <= 1'b0;
        else if (rd_rise && acc_q == DTF_ACC_CMD && adr_q == `DTF_ADR_CMD_STAT)
            intr_pend_q <= 1'b0;
    end

    assign intr_out = intr_pend_q;
    assign intr_oe_n = ~(unit_sel && !ctl_q[`DTF_CTL_INTDIS_BIT]);

    // Data strobes toward the transfer engine
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            xfer_q <= DTF_XFER_IDLE;
        else
        begin
            unique case (xfer_q)
                DTF_XFER_IDLE: if (dreq || dma_req) xfer_q <= DTF_XFER_MOVE;
                DTF_XFER_MOVE: if (!dreq && !dma_req) xfer_q <= DTF_XFER_IDLE;
            endcase
        end
    end

    logic pio_hit;
    assign pio_hit = acc_q == DTF_ACC_CMD && adr_q == `DTF_ADR_DATA && !dma_q;
    assign pio_wr_stb = wr_rise && pio_hit && dreq && xfer_q == DTF_XFER_MOVE;
    assign pio_rd_stb = rd_rise && pio_hit && dreq && xfer_q == DTF_XFER_MOVE;
    assign dma_wr_stb = wr_rise && dma_q && xfer_q == DTF_XFER_MOVE;
    assign dma_rd_stb = rd_rise && dma_q && xfer_q == DTF_XFER_MOVE;

    // Read data registered on the leading edge of the read strobe
    logic reading_q;
    logic [15:0] rd_mux;
    logic [15:0] rd_oe_mux;
    always_comb
    begin
        rd_mux = 16'h0000;
        rd_oe_mux = 16'hffff;
        if (!dma_ack_n && dma_req)
        begin
            rd_mux = dma_rd_word;
            rd_oe_mux = 16'h0000;
        end
        else if (acc_d == DTF_ACC_CMD)
        begin
            rd_oe_mux = 16'hff00;
            unique case (reg_adr)
                `DTF_ADR_DATA:
                begin
                    rd_mux = wide_xfer ? pio_rd_word : {8'h00, pio_rd_word[7:0]};
                    rd_oe_mux = wide_xfer ? 16'h0000 : 16'hff00;
                end
                `DTF_ADR_ERR_FEAT: rd_mux = {8'h00, err_in};
                `DTF_ADR_SECT_CNT: rd_mux = {8'h00, cnt_q};
                `DTF_ADR_SECT_NUM: rd_mux = {8'h00, sect_q};
                `DTF_ADR_CYL_LOW: rd_mux = {8'h00, cyl_low_q};
                `DTF_ADR_CYL_HIGH: rd_mux = {8'h00, cyl_high_q};
                `DTF_ADR_UNIT_HEAD: rd_mux = {8'h00, uh_q};
                `DTF_ADR_CMD_STAT: rd_mux = {8'h00, dev_status};
                default: ;
            endcase
        end
        else if (acc_d == DTF_ACC_CTL && reg_adr == `DTF_ADR_CTL)
        begin
            rd_mux = {8'h00, dev_status};
            rd_oe_mux = 16'hff00;
        end
        // Obsolete control address 7 left undriven, bit 7 never driven
    end

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            dd_out <= 16'h0000;
            dd_oe_n <= 16'hffff;
            reading_q <= 1'b0;
        end
        else if (rd_fall)
        begin
            dd_out <= rd_mux;
            dd_oe_n <= rd_oe_mux;
            reading_q <= 1'b1;
        end
        else if (rd_rise || !reading_q)
        begin
            dd_oe_n <= 16'hffff;
            reading_q <= 1'b0;
        end
    end

    a_bit7_obsolete: assert property (@(posedge sys_clk) disable iff (!nrst)
        rd_fall && acc_d == DTF_ACC_CTL && reg_adr == `DTF_ADR_OBSOLETE |=> dd_oe_n[7])
        else $error("obsolete address drove bit 7");
    a_alt_keep_intr: assert property (@(posedge sys_clk) disable iff (!nrst)
        rd_rise && acc_q == DTF_ACC_CTL && intr_pend_q && !soft_rst_q && !cmd_start
        |=> intr_pend_q)
        else $error("alternate status read cleared interrupt");
    a_stat_clr_intr: assert property (@(posedge sys_clk) disable iff (!nrst)
        rd_rise && acc_q == DTF_ACC_CMD && adr_q == `DTF_ADR_CMD_STAT && !intr_raise
        |=> !intr_pend_q)
        else $error("status read left interrupt pending");
    a_cmd_start: assert property (@(posedge sys_clk) disable iff (!nrst)
        wr_cmd && adr_q == `DTF_ADR_CMD_STAT && !busy && !dreq
        |=> cmd_start && cmd_code_q == $past(dd_in[7:0]))
        else $error("command write did not start");
    a_ctl_bit0: assert property (@(posedge sys_clk) disable iff (!nrst) !ctl_q[0])
        else $error("control bit 0 set");
    a_ctl_write: assert property (@(posedge sys_clk) disable iff (!nrst)
        wr_ctl |=> ctl_q[2:1] == $past(dd_in[2:1]))
        else $error("control write not effective");
    a_intr_tristate: assert property (@(posedge sys_clk) disable iff (!nrst)
        ctl_q[`DTF_CTL_INTDIS_BIT] || !unit_sel |-> intr_oe_n)
        else $error("interrupt driven while disabled");
    a_fail_cyl: assert property (@(posedge sys_clk) disable iff (!nrst)
        media_fail |=> {cyl_high_q, cyl_low_q} == $past(fail_cyl)
        && uh_q[3:0] == $past(fail_head))
        else $error("error address not loaded");
    a_pio_gate: assert property (@(posedge sys_clk) disable iff (!nrst)
        pio_wr_stb || pio_rd_stb |-> dreq)
        else $error("pio strobe without data request");
    a_dma_wide: assert property (@(posedge sys_clk) disable iff (!nrst)
        rd_fall && !dma_ack_n && dma_req |=> dd_oe_n == 16'h0000)
        else $error("dma read not 16 bits");
    a_unit_now: assert property (@(posedge sys_clk) disable iff (!nrst)
        wr_cmd && !busy && !media_fail && adr_q == `DTF_ADR_UNIT_HEAD
        |=> uh_q[`DTF_UH_DEV_BIT] == $past(dd_in[4]))
        else $error("device bit not effective");
endmodule : dtf_regs
`default_nettype wire

// ==== verif/dtf_host_model.sv ====
// Host adapter model driving selects, address, strobes and write data
`timescale 1ns/1ps
`default_nettype none
module dtf_host_model (
    input wire logic sys_clk,
    input wire logic [15:0] dd_out,
    input wire logic [15:0] dd_oe_n,
    output logic cmd_sel_n,
    output logic ctl_sel_n,
    output logic [2:0] reg_adr,
    output logic rd_n,
    output logic wr_n,
    output logic dma_ack_n,
    output logic [15:0] dd_in
);
    initial
    begin
        cmd_sel_n = 1'b1;
        ctl_sel_n = 1'b1;
        reg_adr = 3'h0;
        rd_n = 1'b1;
        wr_n = 1'b1;
        dma_ack_n = 1'b1;
        dd_in = 16'h5a5a;
    end
    // Sel 0 command block, 1 control block, 2 DMA port, 3 both selects
    task automatic cycle(input logic rd, input int sel, input logic [2:0] adr,
        input logic [15:0] wd, output logic [15:0] rdv, output logic [15:0] oe);
        @(posedge sys_clk);
        cmd_sel_n <= !(sel == 0 || sel == 3);
        ctl_sel_n <= !(sel == 1 || sel == 3);
        dma_ack_n <= (sel != 2);
        reg_adr <= adr;
        dd_in <= (sel == 1) ? {wd[15:1], 1'b0} : wd;
        rd_n <= !rd;
        wr_n <= rd;
        // Three edges low, past the two-cycle minimum
        repeat (3) @(posedge sys_clk);
        rdv = dd_out;
        oe = dd_oe_n;
        rd_n <= 1'b1;
        wr_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
        cmd_sel_n <= 1'b1;
        ctl_sel_n <= 1'b1;
        dma_ack_n <= 1'b1;
        // Released bus shows the inverse so stale data cannot pass
        dd_in <= ~wd;
    endtask : cycle
endmodule : dtf_host_model
`default_nettype wire

// ==== verif/tb_disk_task_file_registers.sv ====
// Self-checking bench for the task file register bank
`timescale 1ns/1ps
`default_nettype none
module tb_disk_task_file_registers;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic cmd_sel_n, ctl_sel_n, rd_n, wr_n, dma_ack_n, intr_out, intr_oe_n, intr_raise;
    logic dma_req, wide_xfer, media_fail, cmd_start, soft_rst_q, unit_sel, pio_wr_stb, dma_wr_stb;
    logic [2:0] reg_adr;
    logic [3:0] fail_head;
    logic pio_rd_stb, dma_rd_stb;
    logic [7:0] dev_status, cmd_code_q, prm_uh_q, prm_feat_q, prm_cnt_q, prm_sect_q;
    logic [15:0] dd_in, dd_out, dd_oe_n, pio_rd_word, dma_rd_word, fail_cyl, wr_word_q;
    logic [15:0] prm_cyl_q, rv, oe, w;
    int n_mismatch = 0;
    int n_checks = 0;
    int cycles = 0;
    int seed = 32'h46cd;
    int n_pio = 0;
    int n_dma = 0;
    int n_rds = 0;
    int exp_reg [8];
    int cmd_q [$];

    always #25 sys_clk = ~sys_clk;

    dtf_host_model dtf_host_model_inst (.sys_clk(sys_clk), .dd_out(dd_out), .dd_oe_n(dd_oe_n),
        .cmd_sel_n(cmd_sel_n), .ctl_sel_n(ctl_sel_n), .reg_adr(reg_adr), .rd_n(rd_n),
        .wr_n(wr_n), .dma_ack_n(dma_ack_n), .dd_in(dd_in));

    dtf_regs dtf_regs_inst (.sys_clk(sys_clk), .nrst(nrst), .cmd_sel_n(cmd_sel_n),
        .ctl_sel_n(ctl_sel_n), .reg_adr(reg_adr), .rd_n(rd_n), .wr_n(wr_n),
        .dma_ack_n(dma_ack_n), .dd_in(dd_in), .dd_out(dd_out), .dd_oe_n(dd_oe_n),
        .intr_out(intr_out), .intr_oe_n(intr_oe_n), .dev_status(dev_status),
        .intr_raise(intr_raise), .dma_req(dma_req), .wide_xfer(wide_xfer),
        .media_fail(media_fail), .fail_cyl(fail_cyl), .fail_head(fail_head),
        .pio_rd_word(pio_rd_word), .dma_rd_word(dma_rd_word), .cmd_start(cmd_start),
        .cmd_code_q(cmd_code_q), .prm_feat_q(prm_feat_q), .prm_cnt_q(prm_cnt_q),
        .prm_sect_q(prm_sect_q),
        .prm_cyl_q(prm_cyl_q), .prm_uh_q(prm_uh_q), .err_in(), .feat_q(), .cnt_q(),
        .sect_q(), .soft_rst_q(soft_rst_q), .unit_sel(unit_sel), .pio_wr_stb(pio_wr_stb),
        .pio_rd_stb(pio_rd_stb), .dma_wr_stb(dma_wr_stb), .dma_rd_stb(dma_rd_stb),
        .wr_word_q(wr_word_q));

    task automatic results;
        if (n_mismatch == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : results

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        n_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask : chk

    // Model update happens first so the command monitor sees it in time
    task automatic acc(input logic rd, input int sel, input logic [2:0] adr, input logic [15:0] wd);
        if (!rd && sel == 0 && dev_status[7] === 1'b0 && dev_status[3] === 1'b0)
        begin
            if (adr == 3'h7)
                cmd_q.push_back(wd[7:0]);
            else if (adr != 3'h0)
                exp_reg[adr] = wd[7:0];
        end
        dtf_host_model_inst.cycle(rd, sel, adr, wd, rv, oe);
    endtask : acc

    task automatic rdc(input int sel, input logic [2:0] adr, input logic [15:0] exp,
        input logic [15:0] exp_oe);
        acc(1'b1, sel, adr, 16'h0000);
        chk(rv, exp, "read data");
        chk(oe, exp_oe, "read enables");
    endtask : rdc

    always @(posedge sys_clk)
    begin
        cycles++;
        if (pio_wr_stb === 1'b1)
            n_pio++;
        if (dma_wr_stb === 1'b1)
            n_dma++;
        if (pio_rd_stb === 1'b1 || dma_rd_stb === 1'b1)
            n_rds++;
        if (cmd_start === 1'b1)
        begin
            if (cmd_q.size() == 0)
                chk(16'h0001, 16'h0000, "command start while refused");
            else
            begin
                chk({8'h00, cmd_code_q}, 16'(cmd_q.pop_front()), "command code");
                chk(prm_cyl_q, 16'((exp_reg[5] << 8) | exp_reg[4]), "cylinder snapshot");
                chk({8'h00, prm_uh_q}, 16'(exp_reg[6]), "unit head snapshot");
                chk({8'h00, prm_feat_q}, 16'(exp_reg[1]), "features snapshot");
                chk({8'h00, prm_cnt_q}, 16'(exp_reg[2]), "count snapshot");
                chk({8'h00, prm_sect_q}, 16'(exp_reg[3]), "sector snapshot");
            end
        end
        if (cycles == 5000)
        begin
            n_mismatch++;
            results();
        end
    end

    initial
    begin
        dev_status = 8'h40;
        intr_raise = 1'b0;
        dma_req = 1'b0;
        wide_xfer = 1'b1;
        media_fail = 1'b0;
        fail_cyl = 16'h0000;
        fail_head = 4'h0;
        pio_rd_word = 16'h0000;
        dma_rd_word = 16'h0000;
        exp_reg = '{default: 0};
        exp_reg[6] = 8'ha0;
        repeat (12) @(posedge sys_clk);
        nrst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rdc(0, 3'h6, 16'h00a0, 16'hff00);
        chk({15'h0000, intr_oe_n}, 16'h0000, "interrupt drive after reset");
        for (int i = 0; i < 4; i++)
        begin
            for (int a = 1; a < 7; a++)
            begin
                w = 16'($random(seed));
                if (a == 6)
                    w[7:0] = (w[7:0] & 8'h4f) | 8'ha0;
                acc(1'b0, 0, a[2:0], w);
            end
            for (int a = 2; a < 7; a++)
                rdc(0, a[2:0], 16'(exp_reg[a]), 16'hff00);
            acc(1'b0, 0, 3'h7, 16'($random(seed)));
        end
        intr_raise <= 1'b1;
        @(posedge sys_clk);
        intr_raise <= 1'b0;
        rdc(1, 3'h6, 16'h0040, 16'hff00);
        chk({15'h0000, intr_out}, 16'h0001, "pending after mirror read");
        rdc(0, 3'h7, 16'h0040, 16'hff00);
        chk({15'h0000, intr_out}, 16'h0000, "pending after status read");
        for (int a = 0; a < 6; a++)
        begin
            acc(1'b1, 1, a[2:0], 16'h0000);
            chk(oe, 16'hffff, "control decode");
        end
        acc(1'b1, 1, 3'h7, 16'h0000);
        chk({15'h0000, oe[7]}, 16'h0001, "obsolete bit seven");
        acc(1'b1, 3, 3'h7, 16'h0000);
        chk(oe, 16'hffff, "both selects");
        acc(1'b0, 1, 3'h6, 16'h0002);
        chk({15'h0000, intr_oe_n}, 16'h0001, "interrupt disabled");
        acc(1'b0, 1, 3'h6, 16'h0005);
        chk({14'h0000, soft_rst_q, intr_oe_n}, 16'h0002, "software reset");
        acc(1'b0, 1, 3'h6, 16'h0000);
        acc(1'b0, 0, 3'h6, 16'h00b0);
        chk({14'h0000, unit_sel, intr_oe_n}, 16'h0001, "other unit");
        acc(1'b0, 0, 3'h6, 16'h00a0);
        chk({14'h0000, soft_rst_q, intr_oe_n}, 16'h0000, "unit and control back");
        dev_status <= 8'hd0;
        // Let busy settle before the model decides whether the write lands
        @(posedge sys_clk);
        acc(1'b0, 0, 3'h4, ~16'(exp_reg[4]));
        acc(1'b0, 0, 3'h7, 16'h00ec);
        rdc(0, 3'h4, 16'(exp_reg[4]), 16'hff00);
        dev_status <= 8'h58;
        for (int k = 0; k < 2; k++)
        begin
            w = 16'($random(seed));
            wide_xfer <= (k == 0);
            acc(1'b0, 0, 3'h0, w);
            chk(wr_word_q, (k == 0) ? w : {8'h00, w[7:0]}, "data register word");
        end
        wide_xfer <= 1'b1;
        pio_rd_word <= 16'($random(seed));
        @(posedge sys_clk);
        rdc(0, 3'h0, pio_rd_word, 16'h0000);
        dev_status <= 8'h50;
        acc(1'b0, 0, 3'h0, 16'h1234);
        chk(16'(n_pio), 16'h0002, "data strobes only with request");
        dma_req <= 1'b1;
        wide_xfer <= 1'b0;
        dma_rd_word <= 16'($random(seed));
        w = 16'($random(seed));
        acc(1'b0, 2, 3'h0, w);
        chk(wr_word_q, w, "port word");
        chk(16'(n_dma), 16'h0001, "port strobes");
        rdc(2, 3'h0, dma_rd_word, 16'h0000);
        dma_req <= 1'b0;
        fail_cyl <= 16'($random(seed));
        fail_head <= 4'($random(seed));
        media_fail <= 1'b1;
        @(posedge sys_clk);
        media_fail <= 1'b0;
        exp_reg[4] = fail_cyl[7:0];
        exp_reg[5] = fail_cyl[15:8];
        exp_reg[6] = (exp_reg[6] & 8'hf0) | fail_head;
        for (int a = 4; a < 7; a++)
            rdc(0, a[2:0], 16'(exp_reg[a]), 16'hff00);
        chk(16'(n_rds), 16'h0002, "read strobes only with request");
        results();
    end
endmodule : tb_disk_task_file_registers
`default_nettype wire
